// >>> core/mvw_mac_wake.sv
`timescale 1ns/100ps
// Function
// [RL1] first tag matched against bytes 13, 14
// [RL2] second tag matched against bytes 13, 14
// [RL3] tagged frames allowed 1522 bytes, not 1518
// [RL4] software programs tag registers to 0x8100
// [RL5] reset clears pointer; writes fill, then advance
// [RL6] pointer wraps after the eighth word
// [RL7] filter port is write-only, reads never advance
// [RL8] unicast enable wakes on global unicast
// [RL9] global unicast: destination bit 0 clear
// [RL10] wake-frame enable arms filter detection
// [RL11] valid wake frame sets its seen flag
// [RL12] magic enable arms magic packet mode
// [RL13] valid magic packet sets its seen flag
// [RL14] magic: six 0xff, sixteen station copies
// [RL15] seen flags sticky until reset or clear
module mvw_mac_wake
    import mvw_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // apb slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // receive frame stream from the phy side
    input  wire logic        rxValid,
    input  wire logic [7:0]  rxData,
    input  wire logic        rxEnd,
    // per-frame result
    output logic             frameChecked,
    output logic             vlanFirst,
    output logic             vlanSecond,
    output logic             frameTooLong,
    // power management and interrupt
    output logic             powerSave,
    output logic             wakeEvent,
    output logic             irq
);
    typedef struct packed {
        logic [15:0]          firstTag;   // first tag identifier
        logic [15:0]          secondTag;  // second tag identifier
        logic [7:0][31:0]     filt;       // wake filter words
        logic [2:0]           filtPtr;    // next filter word
        logic                 unicastEn;  // unicast wake enable
        logic                 frameEn;    // wake frame enable
        logic                 magicEn;    // magic wake enable
        logic                 frameSeen;  // wake frame seen
        logic                 magicSeen;  // magic frame seen
        logic [47:0]          station;    // own address
        logic [IRQ_BITS-1:0]  irqStat;    // sticky events
        logic [IRQ_BITS-1:0]  irqMask;    // event enables
        logic                 powerSave;  // low power mode
        logic [11:0]          byteCount;  // bytes of frame so far
        logic [15:0]          tagWord;    // bytes 13 and 14
        logic                 unicastDst; // destination bit 0 clear
        logic                 frameDone;  // frame end, one cycle late
        logic [11:0]          lastLen;    // length of last frame
        logic                 chkValid;   // result pulse
        logic                 chkFirst;   // last frame first tag
        logic                 chkSecond;  // last frame second tag
        logic                 chkLong;    // last frame too long
        logic                 wakeEvent;  // wake pulse
        logic [31:0]          prdata;     // read data
    } mvw_state_type;

    mvw_state_type    s_reg;       // registered state
    mvw_state_type    s_next;      // next state
    logic [9:0]       index;       // word index from address
    logic             setup;       // apb setup phase
    logic             access;      // apb access phase
    logic             mapped;      // address decodes
    logic [31:0]      rdData;      // read mux
    logic             first;       // current byte opens a frame
    logic [15:0]      crcNow [FILTERS];
    logic [FILTERS-1:0] filterHit; // per-filter match
    logic             magicFound;  // magic pattern in frame
    logic             isFirst;     // tag matches first id
    logic             isSecond;    // tag matches second id
    logic [11:0]      maxLen;      // legal length limit
    logic             tooLong;     // frame over the limit
    logic             wakeHit;     // wake frame accepted
    logic             magicHit;    // magic packet accepted
    logic             uniHit;      // unicast wake accepted

    assign index  = paddr[11:2];
    assign setup  = psel && !penable;
    assign access = psel && penable;
    assign first  = s_reg.byteCount == '0;

    // one checksum per filter, shared stream
    for (genvar i = 0; i < FILTERS; i++) begin : g_filt
        mvw_filter_crc u_crc (
            .sys_clk   (sys_clk),
            .rst       (rst),
            .rxValid   (rxValid),
            .rxData    (rxData),
            .first     (first),
            .byteIndex (s_reg.byteCount),
            .byteMask  (s_reg.filt[i]),
            .offset    (s_reg.filt[FILT_OFS_WORD][8*i +: 8]),
            .crc       (crcNow[i])
        );
        // [RL10] enabled filter with matching sum
        assign filterHit[i] = s_reg.filt[FILT_CMD_WORD][8*i]
            && crcNow[i] == s_reg.filt[FILT_CRC_WORD + i/2][16*(i%2) +: 16];
    end

    // magic packet pattern search
    mvw_magic_detect u_magic (
        .sys_clk (sys_clk),
        .rst     (rst),
        .rxValid (rxValid),
        .rxData  (rxData),
        .first   (first),
        .station (s_reg.station),
        .found   (magicFound)
    );

    // register decode and read mux
    always_comb begin
        mapped = 1'b1;
        rdData = '0;
        case (index)
            IDX_FIRST_TAG:   rdData = {16'h0, s_reg.firstTag};
            IDX_SECOND_TAG:  rdData = {16'h0, s_reg.secondTag};
            // [RL7] filter words never read back
            IDX_FILTER_PORT: rdData = '0;
            IDX_WAKE_CTRL: begin
                rdData[WK_UNICAST_EN] = s_reg.unicastEn;
                rdData[WK_FRAME_SEEN] = s_reg.frameSeen;
                rdData[WK_MAGIC_SEEN] = s_reg.magicSeen;
                rdData[WK_FRAME_EN]   = s_reg.frameEn;
                rdData[WK_MAGIC_EN]   = s_reg.magicEn;
            end
            IDX_STATION_LO:  rdData = s_reg.station[31:0];
            IDX_STATION_HI:  rdData = {16'h0, s_reg.station[47:32]};
            IDX_IRQ_STATUS:  rdData = {28'h0, s_reg.irqStat};
            IDX_IRQ_MASK:    rdData = {28'h0, s_reg.irqMask};
            IDX_RX_STATUS: begin
                rdData[27:16] = s_reg.lastLen;
                rdData[2]     = s_reg.chkLong;
                rdData[1]     = s_reg.chkSecond;
                rdData[0]     = s_reg.chkFirst;
            end
            IDX_POWER_CTRL:  rdData = {31'h0, s_reg.powerSave};
            // unmapped: reads zero, error response
            default:         mapped = 1'b0;
        endcase
    end

    // classify from the frame summary
    always_comb begin
        // [RL1] first tag compare
        isFirst  = s_reg.tagWord == s_reg.firstTag;
        // [RL2] second tag compare
        isSecond = s_reg.tagWord == s_reg.secondTag;
        // [RL3] tagged frames get four extra bytes
        maxLen   = (isFirst || isSecond) ? MAX_LEN_VLAN : MAX_LEN_PLAIN;
        tooLong  = s_reg.lastLen > maxLen;
        // [RL10] filters only count while armed
        wakeHit  = s_reg.frameEn && (|filterHit) && !tooLong;
        // [RL12] magic mode only while armed
        magicHit = s_reg.magicEn && magicFound;
        // [RL8] unicast wake only while asleep
        uniHit   = s_reg.unicastEn && s_reg.unicastDst && s_reg.powerSave;
    end

    // next-state logic: bus accesses first, hardware events last,
    // so an event in the cycle of a clear is kept
    always_comb begin
        s_next           = s_reg;
        s_next.frameDone = 1'b0;
        s_next.chkValid  = 1'b0;
        s_next.wakeEvent = 1'b0;
        // read data caught in setup: no wait state
        if (setup) begin
            s_next.prdata = rdData;
        end
        // register writes at the end of the access phase
        if (access && pwrite) begin
            case (index)
                IDX_FIRST_TAG:  s_next.firstTag  = pwdata[15:0];
                IDX_SECOND_TAG: s_next.secondTag = pwdata[15:0];
                IDX_FILTER_PORT: begin
                    // [RL5] store, then advance pointer
                    s_next.filt[s_reg.filtPtr] = pwdata;
                    s_next.filtPtr = s_reg.filtPtr + 3'h1;
                    // [RL6] wrap to first word
                    if (s_reg.filtPtr == FILT_LAST) begin
                        s_next.filtPtr = '0;
                    end
                end
                IDX_WAKE_CTRL: begin
                    s_next.unicastEn = pwdata[WK_UNICAST_EN];
                    s_next.frameEn   = pwdata[WK_FRAME_EN];
                    s_next.magicEn   = pwdata[WK_MAGIC_EN];
                    // [RL15] write one to clear
                    if (pwdata[WK_FRAME_SEEN]) begin
                        s_next.frameSeen = 1'b0;
                    end
                    if (pwdata[WK_MAGIC_SEEN]) begin
                        s_next.magicSeen = 1'b0;
                    end
                end
                IDX_STATION_LO: s_next.station[31:0]  = pwdata;
                IDX_STATION_HI: s_next.station[47:32] = pwdata[15:0];
                IDX_IRQ_MASK:   s_next.irqMask = pwdata[IRQ_BITS-1:0];
                IDX_POWER_CTRL: s_next.powerSave = pwdata[0];
                // others ignore writes
                default: ;
            endcase
        end
        // reading the event register empties it
        if (access && !pwrite && index == IDX_IRQ_STATUS) begin
            s_next.irqStat = '0;
        end
        // receive byte bookkeeping
        if (rxValid) begin
            if (s_reg.byteCount != LEN_SATURATE) begin
                s_next.byteCount = s_reg.byteCount + 12'h1;
            end
            // [RL9] group bit of the destination address
            if (s_reg.byteCount == DST_FIRST_BYTE) begin
                s_next.unicastDst = !rxData[0];
            end
            // [RL1] capture the tag bytes
            if (s_reg.byteCount == TAG_BYTE_HI) begin
                s_next.tagWord[15:8] = rxData;
            end
            if (s_reg.byteCount == TAG_BYTE_LO) begin
                s_next.tagWord[7:0] = rxData;
            end
            if (rxEnd) begin
                s_next.lastLen   = s_next.byteCount;
                s_next.byteCount = '0;
                s_next.frameDone = 1'b1;
            end
        end
        // judge frame after checksums took last byte
        if (s_reg.frameDone) begin
            s_next.chkValid  = 1'b1;
            s_next.chkFirst  = isFirst;
            s_next.chkSecond = isSecond;
            s_next.chkLong   = tooLong;
            if (tooLong) begin
                s_next.irqStat[IRQ_TOO_LONG] = 1'b1;
            end
            // [RL11] wake frame sets its flag
            if (wakeHit) begin
                s_next.frameSeen = 1'b1;
                s_next.irqStat[IRQ_WAKE_FRAME] = 1'b1;
            end
            // [RL13] magic packet sets its flag
            if (magicHit) begin
                s_next.magicSeen = 1'b1;
                s_next.irqStat[IRQ_MAGIC] = 1'b1;
            end
            if (uniHit) begin
                s_next.irqStat[IRQ_UNICAST] = 1'b1;
            end
            // [RL8] any accepted wake cause leaves power saving
            if (s_reg.powerSave && (wakeHit || magicHit || uniHit)) begin
                s_next.powerSave = 1'b0;
                s_next.wakeEvent = 1'b1;
            end
        end
    end

    // [RL5] reset also clears the filter pointer
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs
    assign prdata       = s_reg.prdata;
    assign pready       = 1'b1;
    assign pslverr      = access && !mapped;
    assign frameChecked = s_reg.chkValid;
    assign vlanFirst    = s_reg.chkFirst;
    assign vlanSecond   = s_reg.chkSecond;
    assign frameTooLong = s_reg.chkLong;
    assign powerSave    = s_reg.powerSave;
    assign wakeEvent    = s_reg.wakeEvent;
    assign irq          = |(s_reg.irqStat & s_reg.irqMask);
endmodule

// >>> include/mvw_pkg.sv
package mvw_pkg;
    // register word indexes; byte address is four times the index
    localparam logic [9:0]  IDX_FIRST_TAG    = 10'h009;
    localparam logic [9:0]  IDX_SECOND_TAG   = 10'h00a;
    localparam logic [9:0]  IDX_FILTER_PORT  = 10'h00b;
    localparam logic [9:0]  IDX_WAKE_CTRL    = 10'h00c;
    localparam logic [9:0]  IDX_STATION_LO   = 10'h010;
    localparam logic [9:0]  IDX_STATION_HI   = 10'h011;
    localparam logic [9:0]  IDX_IRQ_STATUS   = 10'h012;
    localparam logic [9:0]  IDX_IRQ_MASK     = 10'h013;
    localparam logic [9:0]  IDX_RX_STATUS    = 10'h014;
    localparam logic [9:0]  IDX_POWER_CTRL   = 10'h015;
    // wake control and status field positions
    localparam int          WK_UNICAST_EN    = 9;
    localparam int          WK_FRAME_SEEN    = 6;
    localparam int          WK_MAGIC_SEEN    = 5;
    localparam int          WK_FRAME_EN      = 2;
    localparam int          WK_MAGIC_EN      = 1;
    // interrupt status / mask bit positions
    localparam int          IRQ_WAKE_FRAME   = 0;
    localparam int          IRQ_MAGIC        = 1;
    localparam int          IRQ_UNICAST      = 2;
    localparam int          IRQ_TOO_LONG     = 3;
    localparam int          IRQ_BITS         = 4;
    // frame geometry (byte indexes count from zero)
    localparam logic [11:0] TAG_BYTE_HI      = 12'h00c;
    localparam logic [11:0] TAG_BYTE_LO      = 12'h00d;
    localparam logic [11:0] DST_FIRST_BYTE   = 12'h000;
    localparam logic [11:0] MAX_LEN_PLAIN    = 12'd1518;
    localparam logic [11:0] MAX_LEN_VLAN     = 12'd1522;
    localparam logic [11:0] LEN_SATURATE     = 12'hfff;
    // wake-up filter store
    localparam int          FILTERS          = 4;
    localparam int          FILT_CMD_WORD    = 4;
    localparam int          FILT_OFS_WORD    = 5;
    localparam int          FILT_CRC_WORD    = 6;
    localparam logic [2:0]  FILT_LAST        = 3'h7;
    localparam logic [4:0]  FILT_WINDOW_LAST = 5'h1f;
    localparam logic [15:0] CRC_POLY         = 16'h8005;
    localparam logic [15:0] CRC_INIT         = 16'hffff;
    // magic packet pattern
    localparam logic [7:0]  SYNC_BYTE        = 8'hff;
    localparam logic [2:0]  SYNC_RUN         = 3'h6;
    localparam logic [2:0]  MAC_LAST_BYTE    = 3'h5;
    localparam logic [3:0]  MAC_LAST_COPY    = 4'hf;
endpackage

// >>> core/mvw_filter_crc.sv
`timescale 1ns/100ps
module mvw_filter_crc
    import mvw_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // receive byte stream
    input  wire logic        rxValid,
    input  wire logic [7:0]  rxData,
    input  wire logic        first,
    input  wire logic [11:0] byteIndex,
    // filter setup
    input  wire logic [31:0] byteMask,
    input  wire logic [7:0]  offset,
    // running checksum of the selected bytes
    output logic      [15:0] crc
);
    typedef struct packed {
        logic [15:0] crc;
    } mvw_crc_state_type;

    mvw_crc_state_type s_reg;  // registered state
    mvw_crc_state_type s_next; // next state
    logic [11:0]       rel;    // position relative to window start

    // bit-serial crc, lsb first
    function automatic logic [15:0] crcByte(input logic [15:0] c,
                                            input logic [7:0]  d);
        logic [15:0] r;
        r = c;
        for (int b = 0; b < 8; b++) begin
            r = {r[14:0], 1'b0} ^ ((r[15] ^ d[b]) ? CRC_POLY : 16'h0);
        end
        return r;
    endfunction

    // 32-byte window from offset
    always_comb begin
        s_next = s_reg;
        rel    = byteIndex - {4'h0, offset};
        // a new frame restarts the checksum
        if (first) begin
            s_next.crc = CRC_INIT;
        end
        if (rxValid && byteIndex >= {4'h0, offset}
            && rel <= {7'h0, FILT_WINDOW_LAST} && byteMask[rel[4:0]]) begin
            s_next.crc = crcByte(first ? CRC_INIT : s_reg.crc, rxData);
        end
    end

    // state register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign crc = s_reg.crc;
endmodule

// >>> core/mvw_magic_detect.sv
`timescale 1ns/100ps
module mvw_magic_detect
    import mvw_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // receive byte stream
    input  wire logic        rxValid,
    input  wire logic [7:0]  rxData,
    input  wire logic        first,
    // own address, byte 0 first
    input  wire logic [47:0] station,
    // pattern seen in the current frame
    output logic             found
);
    typedef enum logic [1:0] {
        MG_HUNT = 2'b01,  // counting sync bytes
        MG_ADDR = 2'b10   // matching address copies
    } mvw_magic_state_type;

    typedef struct packed {
        mvw_magic_state_type state;
        logic [2:0]          syncCount;
        logic [3:0]          copyCount;
        logic [2:0]          byteCount;
        logic                found;
    } mvw_magic_reg_type;

    mvw_magic_reg_type s_reg;  // registered state
    mvw_magic_reg_type s_next; // next state
    mvw_magic_reg_type base;   // state the byte is judged against
    logic [7:0]        want;   // address byte wanted now

    // pattern search, restarted at every frame
    always_comb begin
        base = s_reg;
        if (first) begin
            base = '0;
            base.state = MG_HUNT;
        end
        s_next = base;
        want = station[8*base.byteCount +: 8];
        if (rxValid) begin
            case (base.state)
                // need six sync bytes in a row
                MG_HUNT: begin
                    if (rxData == SYNC_BYTE) begin
                        s_next.syncCount = base.syncCount + 3'h1;
                        if (base.syncCount + 3'h1 == SYNC_RUN) begin
                            s_next.state     = MG_ADDR;
                            s_next.copyCount = '0;
                            s_next.byteCount = '0;
                        end
                    end else begin
                        s_next.syncCount = '0;
                    end
                end
                // [RL14] sixteen address copies
                MG_ADDR: begin
                    if (rxData == want) begin
                        s_next.byteCount = base.byteCount + 3'h1;
                        if (base.byteCount == MAC_LAST_BYTE) begin
                            s_next.byteCount = '0;
                            s_next.copyCount = base.copyCount + 4'h1;
                            if (base.copyCount == MAC_LAST_COPY) begin
                                s_next.found = 1'b1;
                                s_next.state = MG_HUNT;
                                s_next.syncCount = '0;
                            end
                        end
                    end else if (rxData == SYNC_BYTE && base.copyCount == '0
                                 && base.byteCount == '0) begin
                        // longer sync run: still aligned
                        s_next.state = MG_ADDR;
                    end else begin
                        // broken; sync byte restarts run
                        s_next.state     = MG_HUNT;
                        s_next.syncCount = (rxData == SYNC_BYTE) ? 3'h1 : 3'h0;
                    end
                end
                default: begin
                    s_next.state = MG_HUNT;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_reg       <= '0;
            s_reg.state <= MG_HUNT;
        end else begin
            s_reg <= s_next;
        end
    end

    assign found = s_reg.found;
endmodule

// >>> tb/mvw_mac_wake_checker.sv
`timescale 1ns/100ps
module mvw_mac_wake_checker
    import mvw_pkg::*;
(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // register bus
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // frame stream and results
    input wire logic        rxValid,
    input wire logic        rxEnd,
    input wire logic        frameChecked,
    input wire logic        vlanFirst,
    input wire logic        vlanSecond,
    input wire logic        frameTooLong,
    input wire logic        powerSave,
    input wire logic        wakeEvent
);
    // decoded word
    logic mapped;
    assign mapped = paddr[11:2] inside {[IDX_FIRST_TAG:IDX_WAKE_CTRL],
        [IDX_STATION_LO:IDX_POWER_CTRL]};
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // last byte
    sequence last_byte;
        rxValid && rxEnd;
    endsequence
    // port read setup
    sequence port_read;
        psel && !penable && !pwrite && paddr[11:2] == IDX_FILTER_PORT;
    endsequence
    a_error_on_hole: assert property (psel && penable |-> pslverr == !mapped)
        else $error("bad slave error");
    a_port_reads_zero: assert property (port_read |=> prdata == 32'h0)
        else $error("port read nonzero");
    a_result_two_late: assert property (last_byte |-> ##2 frameChecked)
        else $error("no result");
    a_result_has_cause: assert property (
        frameChecked |-> $past(rxValid && rxEnd, 2))
        else $error("stray result");
    a_result_held: assert property (
        !frameChecked |-> $stable({vlanFirst, vlanSecond, frameTooLong}))
        else $error("result moved");
    a_wake_with_result: assert property (wakeEvent |-> frameChecked)
        else $error("stray wake");
    a_wake_ends_sleep: assert property (
        wakeEvent |-> $past(powerSave) && !powerSave)
        else $error("wake kept sleep");
    a_sleep_exit_cause: assert property (
        $fell(powerSave) |-> wakeEvent || $past(psel && penable && pwrite))
        else $error("bad sleep exit");
endmodule

// >>> tb/mvw_rx_source.sv
`timescale 1ns/100ps
module mvw_rx_source (
    // clock
    input wire logic       sys_clk,
    // byte stream into the mac
    output logic           rxValid,
    output logic     [7:0] rxData,
    output logic           rxEnd
);
    // idle line
    initial {rxValid, rxData, rxEnd} = '0;
    // one byte per edge, random gaps
    task automatic send(input logic [7:0] fr[]);
        foreach (fr[i]) begin
            if ($urandom % 16 == 0) begin
                rxValid <= 1'b0;
                rxData <= ~rxData;
                @(posedge sys_clk);
            end
            rxValid <= 1'b1;
            rxData <= fr[i];
            rxEnd <= i == fr.size() - 1;
            @(posedge sys_clk);
        end
        // released line shows no stale byte
        rxValid <= 1'b0;
        rxEnd <= 1'b0;
        rxData <= ~rxData;
    endtask
endmodule

// >>> tb/mvw_mac_wake_bench.sv
`timescale 1ns/100ps
module mvw_mac_wake_bench
    import mvw_pkg::*;
;
    logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        rxValid, rxEnd, frameChecked, vlanFirst, vlanSecond;
    logic        frameTooLong, powerSave, wakeEvent, irq;
    logic [7:0]  rxData;
    logic [7:0]  fr[];
    logic [15:0] tg, tag2;
    logic [47:0] mac;
    int          n_errors, n_compared;
    int          lens[4] = '{1518, 1519, 1522, 1523};
    mvw_mac_wake u_dut (.sys_clk(sys_clk), .rst(rst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rxValid(rxValid), .rxData(rxData), .rxEnd(rxEnd),
        .frameChecked(frameChecked), .vlanFirst(vlanFirst),
        .vlanSecond(vlanSecond), .frameTooLong(frameTooLong),
        .powerSave(powerSave), .wakeEvent(wakeEvent), .irq(irq));
    mvw_rx_source u_src (.sys_clk(sys_clk), .rxValid(rxValid),
        .rxData(rxData), .rxEnd(rxEnd));
    // one compare, counted
    task chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // apb transfer, data to rd
    task apb(input logic w, input logic [9:0] i, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        k = 0;
        do @(posedge sys_clk); while (pready !== 1'b1 && ++k < 50);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    // random frame, given byte 0 and tag
    task run(input int len, input logic [7:0] d0, input logic [15:0] t);
        int k;
        fr = new[len];
        foreach (fr[i]) fr[i] = 8'($urandom);
        fr[0] = d0;
        fr[12] = t[15:8];
        fr[13] = t[7:0];
        if (len == 120) begin
            for (int i = 0; i < 102; i++) begin
                fr[14 + i] = i < 6 ? 8'hff : mac[8 * ((i - 6) % 6) +: 8];
            end
        end
        u_src.send(fr);
        for (k = 0; frameChecked !== 1'b1 && k < 20; k++) @(posedge sys_clk);
        chk("frameChecked", 1, frameChecked);
    endtask
    // legal length
    function logic too_long(int len, logic vlan);
        return len > (vlan ? 1522 : 1518);
    endfunction
    task final_report;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // watchdog
    initial begin
        repeat (60000) @(posedge sys_clk);
        n_errors++;
        final_report();
    end
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        n_errors = 0;
        n_compared = 0;
        void'($urandom(7));
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        // reset values, one hole
        for (int i = 9; i <= 13; i++) begin
            apb(0, i == 13 ? 10'h020 : 10'(i), 32'h0);
            chk("reset value", 32'h0, rd);
        end
        tag2 = {1'b0, 15'($urandom)} | 16'h0001;
        apb(1, IDX_FIRST_TAG, 32'h00008100);
        apb(1, IDX_SECOND_TAG, {16'h0, tag2});
        // length limits per tag
        for (int t = 0; t < 3; t++) begin
            foreach (lens[l]) begin
                tg = t == 0 ? 16'h0800 : (t == 1 ? 16'h8100 : tag2);
                run(lens[l], 8'h01, tg);
                chk("vlanFirst", t == 1, vlanFirst);
                chk("vlanSecond", t == 2, vlanSecond);
                chk("frameTooLong", too_long(lens[l], t != 0), frameTooLong);
            end
        end
        // port wraps, reads zero
        for (int i = 0; i < 9; i++) apb(1, IDX_FILTER_PORT, $urandom);
        apb(0, IDX_FILTER_PORT, 32'h0);
        chk("wake_filter_port", 32'h0, rd);
        mac = {16'($urandom), $urandom};
        apb(1, IDX_STATION_LO, mac[31:0]);
        apb(1, IDX_STATION_HI, {16'h0, mac[47:32]});
        apb(1, IDX_WAKE_CTRL, 32'h2);
        run(120, 8'h01, 16'h0800);
        chk("irq masked", 0, irq);
        apb(0, IDX_WAKE_CTRL, 32'h0);
        chk("magic seen", 32'h22, rd);
        apb(1, IDX_IRQ_MASK, 32'h1 << IRQ_MAGIC);
        chk("irq raised", 1, irq);
        apb(0, IDX_IRQ_STATUS, 32'h0);
        chk("irq status", 32'h2, rd & 32'h2);
        chk("irq cleared", 0, irq);
        apb(0, IDX_WAKE_CTRL, 32'h0);
        chk("magic sticky", 32'h22, rd);
        apb(1, IDX_WAKE_CTRL, 32'h22);
        apb(0, IDX_WAKE_CTRL, 32'h0);
        chk("magic cleared", 32'h2, rd);
        // unicast wakes
        apb(1, IDX_WAKE_CTRL, 32'h200);
        apb(1, IDX_POWER_CTRL, 32'h1);
        run(64, 8'h01, 16'h0800);
        chk("powerSave kept", 1, powerSave);
        run(64, 8'h02, 16'h0800);
        chk("wakeEvent", 1, wakeEvent);
        chk("powerSave left", 0, powerSave);
        final_report();
    end
endmodule
bind mvw_mac_wake mvw_mac_wake_checker u_chk (.sys_clk(sys_clk),
    .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pslverr(pslverr),
    .rxValid(rxValid), .rxEnd(rxEnd), .frameChecked(frameChecked),
    .vlanFirst(vlanFirst), .vlanSecond(vlanSecond),
    .frameTooLong(frameTooLong), .powerSave(powerSave),
    .wakeEvent(wakeEvent));
